// >>> ppfs_port.sv
// Port pin function switch: one 8-bit port with alternate functions.
// Assumes a CPU-side register port on the system clock, pin levels
// arriving asynchronously, and reset causes flagged by the reset unit.
`timescale 1ns/1ps

module ppfs_port
   import ppfs_pkg::*;
#(
   parameter int W = PPFS_WIDTH
) (
   // Clock and reset
   input  wire logic         CLK_SYS,
   input  wire logic         RESET_N,
   // Reset cause, valid during RESET_N low or as a pulse before a soft reset
   input  wire logic         PIN_RESET_CAUSE,
   input  wire logic         WATCHDOG_RESET_SRC,
   input  wire logic         CLOCK_MONITOR_RESET,
   input  wire logic         LOW_VOLTAGE_RESET,
   // Configuration registers written by software
   input  wire logic [W-1:0] PIN_MODE_CONTROL,
   input  wire logic [W-1:0] FUNCTION_SELECT_LOW,
   input  wire logic [W-1:0] FUNCTION_SELECT_EXT,
   input  wire logic [W-1:0] PULLUP_ENABLE,
   input  wire logic [W-1:0] OPEN_DRAIN_ENABLE,
   input  wire logic [W-1:0] PORT_DIRECTION,
   // Data register access
   input  wire logic [1:0]   DATA_OP,
   input  wire logic [2:0]   DATA_BIT,
   input  wire logic [W-1:0] DATA_WDATA,
   input  wire logic         DATA_RD,
   output logic      [W-1:0] DATA_RDATA,
   output logic      [W-1:0] PORT_DATA_REG,
   // Debug control register
   input  wire logic         DEBUG_CLEAR,
   output logic              DEBUG_ENABLE_BIT,
   output logic              DEBUG_MODE,
   output logic              DEBUG_PINS_EN,
   output logic              DEBUG_PULLDOWN_EN,
   // Peripheral side
   input  wire logic [W-1:0] ALT_OUT,
   input  wire logic [W-1:0] ALT_OE,
   output logic      [W-1:0] ALT_IN,
   // Pins
   input  wire logic [W-1:0] PIN_I,
   output logic      [W-1:0] PIN_O,
   output logic      [W-1:0] PIN_OE,
   output logic      [W-1:0] PIN_PULLUP
);

   //----------------------------------------------------------------
   // Pin synchronisation
   //----------------------------------------------------------------
   logic [W-1:0] pin_s;

   ppfs_sync #(
      .WIDTH    (W)
   ) u_sync (
      .clk      (CLK_SYS),
      .reset_n  (RESET_N),
      .async_in (PIN_I),
      .sync_out (pin_s)
   );

   //----------------------------------------------------------------
   // Data read view
   //----------------------------------------------------------------
   logic [W-1:0] latch_q, latch_d;
   logic [W-1:0] read_val;
   logic [W-1:0] bit_mask;

   // Output pins show the latch, input pins the pin level
   always_comb begin
      read_val = (latch_q & ~PORT_DIRECTION) | (pin_s & PORT_DIRECTION);
      bit_mask = W'(1) << DATA_BIT;
   end

   //----------------------------------------------------------------
   // Output latch
   //----------------------------------------------------------------
   // Whole-port write, or read-modify-write of all 8 bits
   always_comb begin
      latch_d = latch_q;
      case (ppfs_op_t'(DATA_OP))
         PPFS_OP_WRITE: latch_d = DATA_WDATA;
         PPFS_OP_SET:   latch_d = read_val | bit_mask;
         PPFS_OP_CLR:   latch_d = read_val & ~bit_mask;
         PPFS_OP_NONE:  latch_d = latch_q;
         default:       latch_d = latch_q;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         latch_q <= PPFS_LATCH_RST;
      end else begin
         latch_q <= latch_d;
      end
   end

   //----------------------------------------------------------------
   // Read data register
   //----------------------------------------------------------------
   logic [W-1:0] rdata_q, rdata_d;

   always_comb begin
      rdata_d = DATA_RD ? read_val : rdata_q;
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         rdata_q <= PPFS_ZERO8;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   //----------------------------------------------------------------
   // Debug control
   //----------------------------------------------------------------
   // Any RESET_N low restores the debug function, whatever PIN_RESET_CAUSE is; the soft reset inputs keep it
   logic      pin_rst_seen_q, pin_rst_seen_d;
   logic      dbg_en_q, dbg_en_d;
   ppfs_dbg_t dbg_q, dbg_d;
   logic      soft_rst;
   logic      dbg_on_q, dbg_on_d;

   always_comb begin
      soft_rst = WATCHDOG_RESET_SRC | CLOCK_MONITOR_RESET | LOW_VOLTAGE_RESET;
      pin_rst_seen_d = 1'b0;
      dbg_en_d = dbg_en_q;
      dbg_d = dbg_q;
      if (pin_rst_seen_q) begin
         dbg_en_d = PPFS_DBG_EN_RST;
         dbg_d = PPFS_DBG_WAIT;
      end else if (soft_rst) begin
         dbg_en_d = dbg_en_q;
         dbg_d = dbg_q;
      end else begin
         if (DEBUG_CLEAR) begin
            dbg_en_d = 1'b0;
         end
         case (dbg_q)
            PPFS_DBG_WAIT: begin
               if (DEBUG_CLEAR || !dbg_en_q) begin
                  dbg_d = PPFS_DBG_OFF;
               end else if (pin_s[PPFS_DBG_PIN]) begin
                  dbg_d = PPFS_DBG_ON;
               end
            end
            PPFS_DBG_ON: begin
               if (DEBUG_CLEAR) begin
                  dbg_d = PPFS_DBG_OFF;
               end
            end
            PPFS_DBG_OFF: dbg_d = PPFS_DBG_OFF;
            default:      dbg_d = PPFS_DBG_OFF;
         endcase
      end
      // Decode ahead of the flop so the debug outputs come from a register
      dbg_on_d = (dbg_d == PPFS_DBG_ON);
   end

   // Flag set while RESET_N is low and cleared on the first clock after release, whatever PIN_RESET_CAUSE is
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_rst_seen_q <= 1'b1;
         dbg_en_q       <= PPFS_DBG_EN_RST;
         dbg_q          <= PPFS_DBG_WAIT;
         dbg_on_q       <= 1'b0;
      end else begin
         pin_rst_seen_q <= pin_rst_seen_d & PIN_RESET_CAUSE;
         dbg_en_q       <= dbg_en_d;
         dbg_q          <= dbg_d;
         dbg_on_q       <= dbg_on_d;
      end
   end

   //----------------------------------------------------------------
   // Pin and peripheral routing
   //----------------------------------------------------------------
   logic [W-1:0] o_d, oe_d, pu_d, ain_d;
   logic [W-1:0] o_q, oe_q, pu_q, ain_q;
   logic         dbg_pin_own;

   always_comb begin
      dbg_pin_own = (dbg_q != PPFS_DBG_OFF);
      for (int i = 0; i < W; i++) begin
         if (PIN_MODE_CONTROL[i]) begin
            o_d[i]  = ALT_OUT[i];
            oe_d[i] = ALT_OE[i] & (~OPEN_DRAIN_ENABLE[i] | ~ALT_OUT[i]);
         end else begin
            // Open drain drives only low, and only on outputs
            o_d[i]  = latch_q[i];
            oe_d[i] = ~PORT_DIRECTION[i]
                      & (~OPEN_DRAIN_ENABLE[i] | ~latch_q[i]);
         end
         pu_d[i]  = PULLUP_ENABLE[i] & PORT_DIRECTION[i];
         ain_d[i] = PIN_MODE_CONTROL[i] & pin_s[i];
      end
      // Debug reset input owns the shared pin until released
      if (dbg_pin_own) begin
         oe_d[PPFS_DBG_PIN]  = 1'b0;
         ain_d[PPFS_DBG_PIN] = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         o_q   <= PPFS_ZERO8;
         oe_q  <= PPFS_ZERO8;
         pu_q  <= PPFS_ZERO8;
         ain_q <= PPFS_ZERO8;
      end else begin
         o_q   <= o_d;
         oe_q  <= oe_d;
         pu_q  <= pu_d;
         ain_q <= ain_d;
      end
   end

   //----------------------------------------------------------------
   // Outputs
   //----------------------------------------------------------------
   assign PIN_O             = o_q;
   assign PIN_OE            = oe_q;
   assign PIN_PULLUP        = pu_q;
   assign ALT_IN            = ain_q;
   assign PORT_DATA_REG     = latch_q;
   assign DATA_RDATA        = rdata_q;
   assign DEBUG_ENABLE_BIT  = dbg_en_q;
   assign DEBUG_MODE        = dbg_on_q;
   assign DEBUG_PINS_EN     = dbg_on_q;
   assign DEBUG_PULLDOWN_EN = dbg_en_q;

endmodule : ppfs_port

// >>> ppfs_pkg.sv
// Constants and types for the port pin function switch.
// Assumes one 10 MHz system clock and an asynchronous active-low reset.
//
// How it works
// - A pin is a plain port while its mode-control bit is 0 and is routed to its peripheral when the bit is 1.
// - A data read returns the output latch for output pins and the synchronised pin level for input pins, in either mode.
// - A data write only ever updates the output latch, whatever mode the pin is in.
// - The input handed to a peripheral is the mode-control bit ANDed with the pin level, and 0 on the debug pin until the debug function is released.
// - In port mode the open-drain bit acts only on output pins and is ignored on input pins.
// - A 0 to 1 mode change on a high pin looks like a rising edge, so the valid edge is programmed after the switch.
// - A 1 to 0 mode change on a high pin looks like a falling edge, so edge detection is set to none before it.
// - A single-bit set or clear is an 8-bit read, one bit changed, and an 8-bit write, so input latches take pin levels.
// - After an external-pin reset the shared pin is the debug reset input and a high level enters debug mode with the debug pins enabled.
// - Watchdog, clock monitor and low-voltage resets leave the pin function and the debug control register unchanged.
// - The pull-down on the debug reset pin is on after an external-pin reset and off once the debug-enable bit is cleared.

package ppfs_pkg;

   //----------------------------------------------------------------
   // Port geometry and reset values
   //----------------------------------------------------------------
   localparam int        PPFS_WIDTH       = 8;       // One 8-bit port
   localparam int        PPFS_DBG_PIN     = 5;       // Pin shared with the debug reset
   localparam logic [7:0] PPFS_LATCH_RST  = 8'h00;
   localparam logic [7:0] PPFS_DIR_RST    = 8'hff;   // All pins input after reset
   localparam logic [7:0] PPFS_MODE_RST   = 8'h00;   // All pins port mode after reset
   localparam logic [7:0] PPFS_ZERO8      = 8'h00;
   localparam logic       PPFS_DBG_EN_RST = 1'b1;    // Debug reset function after pin reset

   //----------------------------------------------------------------
   // Bit-operation codes for the data register access
   //----------------------------------------------------------------
   typedef enum logic [1:0] {
      PPFS_OP_NONE  = 2'b00,
      PPFS_OP_WRITE = 2'b01,
      PPFS_OP_SET   = 2'b10,
      PPFS_OP_CLR   = 2'b11
   } ppfs_op_t;

   //----------------------------------------------------------------
   // Debug pin state
   //----------------------------------------------------------------
   typedef enum logic [1:0] {
      PPFS_DBG_WAIT = 2'b00,   // Debug reset function, not yet in debug mode
      PPFS_DBG_ON   = 2'b01,   // On-chip debug mode entered
      PPFS_DBG_OFF  = 2'b10    // Debug function released to the port
   } ppfs_dbg_t;

endpackage : ppfs_pkg

// >>> ppfs_sync.sv
// Two-flop synchroniser for a vector of asynchronous pin levels.
// Assumes the inputs come from pins outside the system clock domain.
`timescale 1ns/1ps

module ppfs_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   //----------------------------------------------------------------
   // Register stage
   //----------------------------------------------------------------
   // First flop feeds only the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule : ppfs_sync

// >>> ppfs_chk.sv
// Checker for the port pin function switch, bound to its top module.
// Assumes one clock domain and the 8-bit port of the package.
`timescale 1ns/1ps
module ppfs_chk
   import ppfs_pkg::*;
#(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic         CLK_SYS,
   input wire logic         RESET_N,
   // Stimulus at the ports
   input wire logic         WATCHDOG_RESET_SRC,
   input wire logic         DEBUG_CLEAR,
   input wire logic [1:0]   DATA_OP,
   input wire logic [2:0]   DATA_BIT,
   input wire logic [W-1:0] DATA_WDATA,
   input wire logic [W-1:0] PIN_MODE_CONTROL,
   input wire logic [W-1:0] OPEN_DRAIN_ENABLE,
   input wire logic [W-1:0] PORT_DIRECTION,
   input wire logic [W-1:0] ALT_OE,
   input wire logic [W-1:0] PIN_I,
   // Design outputs
   input wire logic [W-1:0] PORT_DATA_REG,
   input wire logic [W-1:0] ALT_IN,
   input wire logic [W-1:0] PIN_OE,
   input wire logic         DEBUG_ENABLE_BIT,
   input wire logic         DEBUG_MODE,
   input wire logic         DEBUG_PINS_EN,
   input wire logic         DEBUG_PULLDOWN_EN
);
   //------------------------------
   // Properties
   //------------------------------
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   wr_latch_a: assert property (DATA_OP == 2'h1 |=>
      PORT_DATA_REG == $past(DATA_WDATA)) else $error("latch missed a write");
   bit_set_a: assert property (DATA_OP == 2'h2 |=>
      PORT_DATA_REG[$past(DATA_BIT)]) else $error("bit set lost");
   bit_clr_a: assert property (DATA_OP == 2'h3 |=>
      !PORT_DATA_REG[$past(DATA_BIT)]) else $error("bit clear lost");
   alt_gate_a: assert property (
      (ALT_IN & ~$past(PIN_MODE_CONTROL)) == '0) else $error("peripheral input not gated");
   od_input_a: assert property (
      (PIN_OE & $past(PORT_DIRECTION) & ~$past(PIN_MODE_CONTROL)) == '0)
      else $error("input pin driven");
   // Reset-time history is skipped: the outputs are still cleared there
   alt_route_a: assert property ($past(RESET_N) |->
      ((PIN_OE ^ $past(ALT_OE)) & $past(PIN_MODE_CONTROL) & ~$past(OPEN_DRAIN_ENABLE)
      & ~(W'(1) << PPFS_DBG_PIN)) == '0) else $error("peripheral enable not routed");
   dbg_clear_a: assert property (DEBUG_CLEAR |=>
      !DEBUG_ENABLE_BIT && !DEBUG_PULLDOWN_EN) else $error("debug clear ignored");
   dbg_hold_a: assert property (WATCHDOG_RESET_SRC && !DEBUG_CLEAR |=>
      $stable(DEBUG_ENABLE_BIT)) else $error("soft reset moved debug enable");
   dbg_enter_a: assert property ((DEBUG_ENABLE_BIT && PIN_I[PPFS_DBG_PIN]) [*5] |->
      DEBUG_MODE && DEBUG_PINS_EN) else $error("debug mode not entered");
   cover property (DATA_OP == 2'h2);
   cover property ($fell(DEBUG_ENABLE_BIT));
   cover property (DEBUG_MODE && DEBUG_PINS_EN);
endmodule : ppfs_chk

// >>> ppfs_board.sv
// Board model: the circuitry outside the port pins.
// Assumes the board drives every line through a series resistor.
`timescale 1ns/1ps
module ppfs_board #(
   parameter int W = 8
) (
   // Board drive
   input  wire logic [W-1:0] board_val,
   // Device pins
   input  wire logic [W-1:0] pin_o,
   input  wire logic [W-1:0] pin_oe,
   output logic      [W-1:0] pin_lvl
);
   // Device overpowers the resistor; the board keeps the debug pin low
   // unless a debugger is meant to be attached
   assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & board_val);
endmodule : ppfs_board

// >>> ppfs_port_tb.sv
// Self-checking bench for the port pin function switch.
// Assumes the checker and the board model are compiled before it.
`timescale 1ns/1ps
module ppfs_port_tb
   import ppfs_pkg::*;
;
   localparam int W = PPFS_WIDTH;
   logic         clk = 1'b0, rst_n = 1'b0, cause = 1'b1, rd = 1'b0, dclr = 1'b0;
   logic         wdog = 1'b0, cmon = 1'b0, lowv = 1'b0;
   logic [1:0]   op = 2'h0;
   logic [2:0]   bsel = 3'h0;
   logic [W-1:0] mode = '0, fsl = '0, fse = '0, pu = '0, od = '0, dir = 8'hff;
   logic [W-1:0] wd = '0, aout = '0, aoe = '0, brd = '0;
   logic [W-1:0] rdata, latch, ain, lvl, po, poe, ppu, mlat, view, eoe, eo;
   logic         den, dmode, dpins, dpd;
   logic [31:0]  seed = 32'hc6a3, r1, r2;
   int           errors = 0, samples_checked = 0;
   ppfs_port #(.W(W)) u_ppfs_port (
      .CLK_SYS(clk), .RESET_N(rst_n), .PIN_RESET_CAUSE(cause), .WATCHDOG_RESET_SRC(wdog),
      .CLOCK_MONITOR_RESET(cmon), .LOW_VOLTAGE_RESET(lowv), .PIN_MODE_CONTROL(mode),
      .FUNCTION_SELECT_LOW(fsl), .FUNCTION_SELECT_EXT(fse), .PULLUP_ENABLE(pu),
      .OPEN_DRAIN_ENABLE(od), .PORT_DIRECTION(dir), .DATA_OP(op), .DATA_BIT(bsel),
      .DATA_WDATA(wd), .DATA_RD(rd), .DATA_RDATA(rdata), .PORT_DATA_REG(latch),
      .DEBUG_CLEAR(dclr), .DEBUG_ENABLE_BIT(den), .DEBUG_MODE(dmode), .DEBUG_PINS_EN(dpins),
      .DEBUG_PULLDOWN_EN(dpd), .ALT_OUT(aout), .ALT_OE(aoe), .ALT_IN(ain), .PIN_I(lvl),
      .PIN_O(po), .PIN_OE(poe), .PIN_PULLUP(ppu));
   ppfs_board #(.W(W)) u_ppfs_board (.board_val(brd), .pin_o(po), .pin_oe(poe), .pin_lvl(lvl));
   //------------------------------
   // Helpers
   //------------------------------
   initial begin
      forever #50 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One data access: operation and read strobe held for one cycle
   task automatic acc(input logic [1:0] o, input logic [2:0] b, input logic [W-1:0] d,
                      input logic r);
      @(posedge clk);
      op <= o;
      bsel <= b;
      wd <= d;
      rd <= r;
      @(posedge clk);
      op <= 2'h0;
      rd <= 1'b0;
      @(negedge clk);
   endtask : acc
   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   //------------------------------
   // Scenarios
   //------------------------------
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(negedge clk);
      chk({6'h0, den, dpd}, 8'h03);
      chk({7'h0, dmode}, 8'h00);
      @(posedge clk);
      dclr <= 1'b1;
      @(posedge clk);
      dclr <= 1'b0;
      @(negedge clk);
      chk({6'h0, den, dpd}, 8'h00);
      // Each soft reset source in turn must leave debugging released
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         {lowv, cmon, wdog} <= 3'h1 << i;
         @(posedge clk);
         {lowv, cmon, wdog} <= 3'h0;
         @(negedge clk);
         chk({7'h0, den}, 8'h00);
      end
      // Random mixes of mode, direction, open drain, pins and data ops
      @(posedge clk);
      mlat = 8'h00;
      dir <= 8'hfe;
      brd <= 8'hff;
      for (int n = 0; n < 41; n++) begin
         repeat (5) @(posedge clk);
         @(negedge clk);
         eoe = (mode & aoe) | (~mode & ~dir & (~od | ~mlat));
         eo = (mode & aout) | (~mode & mlat);
         chk(poe, eoe);
         chk(po & eoe, eo & eoe);
         chk(ain, mode & ((eoe & eo) | (~eoe & brd)));
         r1 = (n == 0) ? 32'h2 : rnd();
         acc(r1[1:0], r1[4:2], r1[15:8], 1'b0);
         view = (mlat & ~dir) | (brd & dir);
         if (r1[1:0] == 2'h1)
            mlat = r1[15:8];
         else if (r1[1])
            mlat = r1[0] ? view & ~(8'h1 << r1[4:2]) : view | (8'h1 << r1[4:2]);
         chk(latch, mlat);
         acc(2'h0, 3'h0, 8'h00, 1'b1);
         chk(rdata, (mlat & ~dir) | (brd & dir));
         chk(ppu, pu & dir);
         @(posedge clk);
         r1 = rnd();
         r2 = rnd();
         dir <= r1[7:0];
         mode <= r1[15:8];
         brd <= r1[23:16];
         od <= r1[31:24] & ~r1[15:8];
         aout <= r2[7:0];
         aoe <= r2[15:8] & ~r1[7:0];
         fsl <= r2[23:16];
         fse <= r2[31:24];
         pu <= r2[7:0] ^ r2[31:24];
      end
      // Pin 0 to a peripheral input in the safe order, then back to port
      @(posedge clk);
      mode <= 8'h00;
      dir <= 8'hff;
      od <= 8'h00;
      aoe <= 8'h00;
      pu <= 8'h00;
      brd <= 8'h01;
      fsl <= 8'h01;
      fse <= 8'h00;
      @(posedge clk);
      mode <= 8'h01;
      @(posedge clk);
      pu <= 8'h01;
      repeat (4) @(negedge clk);
      chk(ain, 8'h01);
      chk(ppu, 8'h01);
      @(posedge clk);
      mode <= 8'h00;
      repeat (2) @(negedge clk);
      chk(ain, 8'h00);
      // Pin 0 as open-drain output: mode already cleared, latch rewritten
      @(posedge clk);
      dir <= 8'hfe;
      od <= 8'h01;
      acc(2'h1, 3'h0, 8'h00, 1'b0);
      repeat (2) @(negedge clk);
      chk({6'h0, poe[0], po[0]}, 8'h02);
      acc(2'h1, 3'h0, 8'h01, 1'b0);
      repeat (2) @(negedge clk);
      chk({6'h0, poe[0], lvl[0]}, 8'h01);
      // Open-drain serial function on pin 0: select, open drain, then mode
      @(posedge clk);
      od <= 8'h00;
      fse <= 8'h01;
      aoe <= 8'h01;
      aout <= 8'h00;
      @(posedge clk);
      od <= 8'h01;
      @(posedge clk);
      mode <= 8'h01;
      repeat (2) @(negedge clk);
      chk({6'h0, poe[0], lvl[0]}, 8'h02);
      @(posedge clk);
      aout <= 8'h01;
      repeat (2) @(negedge clk);
      chk({6'h0, poe[0], lvl[0]}, 8'h01);
      // Pin reset with a debugger holding the shared pin high
      @(posedge clk);
      rst_n <= 1'b0;
      brd <= 8'h20;
      mode <= '0;
      dir <= 8'hff;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (7) @(negedge clk);
      chk({4'h0, den, dmode, dpins, poe[5]}, 8'h0e);
      chk({7'h0, dpd}, 8'h01);
      // Soft resets in debug mode keep the debug function and its register
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         {lowv, cmon, wdog} <= 3'h1 << i;
         @(posedge clk);
         {lowv, cmon, wdog} <= 3'h0;
         @(negedge clk);
         chk({6'h0, den, dmode}, 8'h03);
      end
      // Leaving debugging clears the enable and drops the pull-down
      @(posedge clk);
      dclr <= 1'b1;
      @(posedge clk);
      dclr <= 1'b0;
      @(negedge clk);
      chk({5'h0, den, dmode, dpd}, 8'h00);
      finish_test();
   end
   // Watchdog: the run needs well under 1000 cycles
   initial begin
      #300000;
      errors++;
      finish_test();
   end
endmodule : ppfs_port_tb
bind ppfs_port ppfs_chk #(.W(W)) u_ppfs_chk (
   .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .WATCHDOG_RESET_SRC(WATCHDOG_RESET_SRC),
   .DEBUG_CLEAR(DEBUG_CLEAR), .DATA_OP(DATA_OP), .DATA_BIT(DATA_BIT), .DATA_WDATA(DATA_WDATA),
   .PIN_MODE_CONTROL(PIN_MODE_CONTROL), .OPEN_DRAIN_ENABLE(OPEN_DRAIN_ENABLE),
   .PORT_DIRECTION(PORT_DIRECTION), .ALT_OE(ALT_OE), .PIN_I(PIN_I),
   .PORT_DATA_REG(PORT_DATA_REG), .ALT_IN(ALT_IN), .PIN_OE(PIN_OE),
   .DEBUG_ENABLE_BIT(DEBUG_ENABLE_BIT), .DEBUG_MODE(DEBUG_MODE),
   .DEBUG_PINS_EN(DEBUG_PINS_EN), .DEBUG_PULLDOWN_EN(DEBUG_PULLDOWN_EN));
